// ### src/adc_ref_pkg.sv
// package: register indices, field positions, reset values and encodings
// for the converter reference and input selection logic.
// assumes: an 8-bit register port clocked by the system clock.
package adc_ref_pkg;
   // register indices on the plain register port
   localparam logic [1:0] ADDR_REF_GAIN = 2'h0;   // reference_gain_control
   localparam logic [1:0] ADDR_BANDGAP = 2'h1;    // bandgap_control
   localparam logic [1:0] ADDR_CHANNEL = 2'h2;    // external channel select
   localparam logic [1:0] ADDR_SOURCE = 2'h3;     // input source select
   // field positions of reference_gain_control and bandgap_control
   localparam int AMP_EN_BIT = 7;
   localparam int AMP_IN_BIT = 4;
   localparam int REF_SEL_LSB = 2;
   localparam int GAIN_LSB = 0;
   localparam int BG_EN_BIT = 0;
   // writable masks: unimplemented bits hold zero
   localparam logic [7:0] REF_GAIN_MASK = 8'h9f;
   localparam logic [7:0] BANDGAP_MASK = 8'h01;
   localparam logic [7:0] NIBBLE_MASK = 8'h0f;
   // reset values
   localparam logic [7:0] REF_GAIN_RESET = 8'h00;
   localparam logic [7:0] BANDGAP_RESET = 8'h00;
   localparam logic [3:0] NIBBLE_RESET = 4'h0;
   // cycles software waits after enabling the bandgap, plain default
   localparam int BANDGAP_START_CYCLES = 16;
   // number of external analog channels (0..8, 2 reserved)
   localparam int NUM_CHANNELS = 9;
   localparam logic [3:0] LAST_CHANNEL = 4'h8;
   localparam logic [3:0] RESERVED_CHANNEL = 4'h2;
   // converter reference choice (one-hot switch bus)
   typedef enum logic [2:0] {
      REF_SUPPLY = 3'b001,
      REF_EXT_PIN = 3'b010,
      REF_AMP_OUT = 3'b100
   } ref_src_e;
   // internal converter input choice (one-hot switch bus)
   typedef enum logic [7:0] {
      IN_EXTERNAL = 8'b0000_0001,
      IN_SUPPLY = 8'b0000_0010,
      IN_SUPPLY_HALF = 8'b0000_0100,
      IN_SUPPLY_QUARTER = 8'b0000_1000,
      IN_AMP = 8'b0001_0000,
      IN_AMP_HALF = 8'b0010_0000,
      IN_AMP_QUARTER = 8'b0100_0000,
      IN_GROUND = 8'b1000_0000
   } input_src_e;
endpackage

// ### src/adc_reference_input_select.sv
// module: register controlled reference, amplifier and input routing switches
// assumes: clk at 50 MHz, synchronous reset, registers on a plain port with
// read data valid in the cycle after the read strobe.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
module adc_reference_input_select (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // analog channel pin configuration from the pin-function registers
   input wire logic [8:0] pin_analog_sel,
   // amplifier controls
   output logic amp_enable,
   output logic [1:0] amp_gain_select,
   output logic amp_pin_switch,
   output logic amp_bandgap_switch,
   output logic bandgap_enable,
   // converter reference switches, one-hot
   output logic [2:0] ref_switch,
   output logic ref_pin_switch,
   // converter input switches
   output logic [7:0] input_switch,
   output logic [8:0] channel_switch,
   // pin overrides for analog channels
   output logic [8:0] pin_function_off,
   output logic [8:0] pull_high_off,
   output logic [8:0] direction_override
);

   // stored registers
   logic [7:0] ref_gain;      // reference_gain_control
   logic [7:0] bandgap;       // bandgap_control
   logic [3:0] channel_sel;   // external_channel_select
   logic [3:0] source_sel;    // input_source_select
   logic [7:0] next_rdata;    // read mux output

   // write decode
   wire wr_ref_gain = wr && (addr == adc_ref_pkg::ADDR_REF_GAIN);
   wire wr_bandgap = wr && (addr == adc_ref_pkg::ADDR_BANDGAP);
   wire wr_channel = wr && (addr == adc_ref_pkg::ADDR_CHANNEL);
   wire wr_source = wr && (addr == adc_ref_pkg::ADDR_SOURCE);

   // register writes; masks keep unimplemented bits at zero
   always_ff @(posedge clk) begin
      if (srst) begin
         ref_gain <= adc_ref_pkg::REF_GAIN_RESET;
         bandgap <= adc_ref_pkg::BANDGAP_RESET;
         channel_sel <= adc_ref_pkg::NIBBLE_RESET;
         source_sel <= adc_ref_pkg::NIBBLE_RESET;
      end else begin
         if (wr_ref_gain) begin
            ref_gain <= wdata & adc_ref_pkg::REF_GAIN_MASK;
         end
         if (wr_bandgap) begin
            bandgap <= wdata & adc_ref_pkg::BANDGAP_MASK;
         end
         if (wr_channel) begin
            channel_sel <= wdata[3:0];
         end
         if (wr_source) begin
            source_sel <= wdata[3:0];
         end
      end
   end

   // read mux: address decode as an if chain
   always_comb begin
      if (addr == adc_ref_pkg::ADDR_REF_GAIN) begin
         next_rdata = ref_gain;
      end else if (addr == adc_ref_pkg::ADDR_BANDGAP) begin
         next_rdata = bandgap;
      end else if (addr == adc_ref_pkg::ADDR_CHANNEL) begin
         next_rdata = {4'h0, channel_sel};
      end else begin
         next_rdata = {4'h0, source_sel};
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 8'h00;
      end
   end

   // decode an input source nibble into a one-hot switch bus
   function automatic logic [7:0] decode_source(input logic [3:0] s);
      logic [7:0] r;
      r = adc_ref_pkg::IN_EXTERNAL;
      if (s[3:2] == 2'b10) begin
         r = adc_ref_pkg::IN_GROUND;
      end else if (s[3:2] == 2'b11 || s[1:0] == 2'b00) begin
         r = adc_ref_pkg::IN_EXTERNAL;
      end else if (s[2] == 1'b0) begin
         r = (s[1:0] == 2'b01) ? adc_ref_pkg::IN_SUPPLY :
             (s[1:0] == 2'b10) ? adc_ref_pkg::IN_SUPPLY_HALF :
             adc_ref_pkg::IN_SUPPLY_QUARTER;
      end else begin
         r = (s[1:0] == 2'b01) ? adc_ref_pkg::IN_AMP :
             (s[1:0] == 2'b10) ? adc_ref_pkg::IN_AMP_HALF :
             adc_ref_pkg::IN_AMP_QUARTER;
      end
      return r;
   endfunction

   // field views of the stored registers
   wire amp_in_bandgap = ref_gain[adc_ref_pkg::AMP_IN_BIT];
   wire [1:0] ref_field = ref_gain[adc_ref_pkg::REF_SEL_LSB +: 2];
   wire [7:0] src_onehot = decode_source(source_sel);
   wire external_in = src_onehot[0];
   // channel valid: 0..8 except the reserved code
   wire channel_ok = (channel_sel <= adc_ref_pkg::LAST_CHANNEL)
                     && (channel_sel != adc_ref_pkg::RESERVED_CHANNEL);
   wire [8:0] channel_onehot = channel_ok ? (9'h001 << channel_sel) : 9'h000;

   // amplifier and bandgap controls straight from the registers
   assign amp_enable = ref_gain[adc_ref_pkg::AMP_EN_BIT];
   assign amp_gain_select = ref_gain[adc_ref_pkg::GAIN_LSB +: 2];
   assign amp_bandgap_switch = amp_in_bandgap;
   assign amp_pin_switch = !amp_in_bandgap;
   assign bandgap_enable = bandgap[adc_ref_pkg::BG_EN_BIT];

   // reference select: 00 supply, 01 pin, 1x amplifier output
   assign ref_switch = ref_field[1] ? adc_ref_pkg::REF_AMP_OUT :
                       ref_field[0] ? adc_ref_pkg::REF_EXT_PIN :
                       adc_ref_pkg::REF_SUPPLY;
   assign ref_pin_switch = (ref_field == 2'b01);

   // input switches; external paths open for any internal signal
   assign input_switch = src_onehot;
   assign channel_switch = external_in ? channel_onehot : 9'h000;

   // analog channel pins lose their digital functions and pull-highs
   assign pin_function_off = pin_analog_sel;
   assign pull_high_off = pin_analog_sel;
   assign direction_override = pin_analog_sel;

   // checks
   property p_amp_pin_open;
      @(posedge clk) disable iff (srst) amp_in_bandgap |-> !amp_pin_switch;
   endproperty
   a_amp_pin_open: assert property (p_amp_pin_open) else $error("amp pin closed");

   property p_ref_pin_internal;
      @(posedge clk) disable iff (srst) (ref_field != 2'b01) |-> !ref_pin_switch;
   endproperty
   a_ref_pin_internal: assert property (p_ref_pin_internal) else $error("ref pin on");

   property p_no_short;
      @(posedge clk) disable iff (srst) !external_in |-> (channel_switch == 9'h000);
   endproperty
   a_no_short: assert property (p_no_short) else $error("external path on");

   property p_ground;
      @(posedge clk) disable iff (srst)
         (source_sel[3:2] == 2'b10) |-> (input_switch == adc_ref_pkg::IN_GROUND);
   endproperty
   a_ground: assert property (p_ground) else $error("ground not selected");

   sequence s_ref_write;
      wr_ref_gain ##0 (wdata[adc_ref_pkg::AMP_EN_BIT] == 1'b1);
   endsequence
   property p_amp_update;
      @(posedge clk) disable iff (srst) s_ref_write |=> amp_enable;
   endproperty
   a_amp_update: assert property (p_amp_update) else $error("amp not enabled");

   property p_unimpl_zero;
      @(posedge clk) disable iff (srst)
         (rd && addr == adc_ref_pkg::ADDR_REF_GAIN) |=> (rdata[6:5] == 2'b00);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("bits 6:5 set");

   property p_bg_read;
      @(posedge clk) disable iff (srst)
         (rd && addr == adc_ref_pkg::ADDR_BANDGAP) |=> (rdata[7:1] == 7'h00)
         && (rdata[0] == bandgap_enable);
   endproperty
   a_bg_read: assert property (p_bg_read) else $error("bandgap read wrong");

   property p_channel_route;
      @(posedge clk) disable iff (srst)
         (external_in && channel_sel == 4'h3) |-> (channel_switch == 9'h008);
   endproperty
   a_channel_route: assert property (p_channel_route) else $error("channel 3 missing");

   property p_gain;
      @(posedge clk) disable iff (srst)
         wr_ref_gain |=> (amp_gain_select == $past(wdata[1:0]));
   endproperty
   a_gain: assert property (p_gain) else $error("gain not updated");

   // exactly one reference source is closed at any time
   property p_ref_onehot;
      @(posedge clk) disable iff (srst) $onehot(ref_switch);
   endproperty
   a_ref_onehot: assert property (p_ref_onehot) else $error("reference not one-hot");

   // amplifier output as reference keeps the external reference pin open
   property p_ref_amp;
      @(posedge clk) disable iff (srst)
         ref_field[1] |-> (ref_switch == adc_ref_pkg::REF_AMP_OUT) && !ref_pin_switch;
   endproperty
   a_ref_amp: assert property (p_ref_amp) else $error("amp reference wrong");

   // the converter input sees exactly one source
   property p_input_onehot;
      @(posedge clk) disable iff (srst) $onehot(input_switch);
   endproperty
   a_input_onehot: assert property (p_input_onehot) else $error("input not one-hot");

   // at most one external channel is ever closed
   property p_chan_onehot;
      @(posedge clk) disable iff (srst) $onehot0(channel_switch);
   endproperty
   a_chan_onehot: assert property (p_chan_onehot) else $error("two channels closed");

   // reserved and floating channel codes close nothing
   property p_chan_unused;
      @(posedge clk) disable iff (srst)
         (channel_sel == adc_ref_pkg::RESERVED_CHANNEL
         || channel_sel > adc_ref_pkg::LAST_CHANNEL) |-> (channel_switch == 9'h000);
   endproperty
   a_chan_unused: assert property (p_chan_unused) else $error("unused code closed");

   // bandgap enable follows the write one cycle later
   property p_bg_update;
      @(posedge clk) disable iff (srst)
         wr_bandgap |=> (bandgap_enable == $past(wdata[adc_ref_pkg::BG_EN_BIT]));
   endproperty
   a_bg_update: assert property (p_bg_update) else $error("bandgap not updated");

   // selecting the bandgap input swaps both amplifier input switches
   sequence s_amp_in_write;
      wr_ref_gain ##0 wdata[adc_ref_pkg::AMP_IN_BIT];
   endsequence
   property p_amp_in;
      @(posedge clk) disable iff (srst)
         s_amp_in_write |=> amp_bandgap_switch && !amp_pin_switch;
   endproperty
   a_amp_in: assert property (p_amp_in) else $error("input not swapped");

   // a ground code grounds the input and opens every channel
   sequence s_src_ground_write;
      wr_source ##0 (wdata[3:2] == 2'b10);
   endsequence
   property p_gnd_update;
      @(posedge clk) disable iff (srst)
         s_src_ground_write |=> (input_switch == adc_ref_pkg::IN_GROUND)
         && (channel_switch == 9'h000);
   endproperty
   a_gnd_update: assert property (p_gnd_update) else $error("no ground");

   // writing channel 3 under an external source closes that channel only
   sequence s_chan3_write;
      wr_channel ##0 (wdata[3:0] == 4'h3) ##0 external_in;
   endsequence
   property p_chan_update;
      @(posedge clk) disable iff (srst) s_chan3_write |=> (channel_switch == 9'h008);
   endproperty
   a_chan_update: assert property (p_chan_update) else $error("no channel 3");

   // read data is zero except in the cycle after a read strobe
   property p_rdata_idle;
      @(posedge clk) disable iff (srst) !rd |=> (rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("stale read data");

   // a write read back two cycles later returns the stored bits only
   sequence s_ref_set;
      wr_ref_gain ##1 !wr;
   endsequence
   sequence s_ref_get;
      rd && (addr == adc_ref_pkg::ADDR_REF_GAIN);
   endsequence
   property p_ref_readback;
      @(posedge clk) disable iff (srst)
         s_ref_set ##1 s_ref_get
         |=> (rdata == ($past(wdata, 3) & adc_ref_pkg::REF_GAIN_MASK));
   endproperty
   a_ref_readback: assert property (p_ref_readback) else $error("readback wrong");

endmodule // adc_reference_input_select

// ### verification/testbench.sv
// testbench for the converter reference and input selection logic
// assumes: design and package compiled first; plain register port, read data one cycle late
`timescale 1ns/100ps
module testbench;
   // stimulus toward the design
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [8:0] pin_analog_sel = 9'h000;
   // observed outputs
   logic [7:0] rdata, input_switch;
   logic amp_enable, amp_pin_switch, amp_bandgap_switch, bandgap_enable, ref_pin_switch;
   logic [1:0] amp_gain_select;
   logic [2:0] ref_switch;
   logic [8:0] channel_switch, pin_function_off, pull_high_off, direction_override;
   // bookkeeping
   int num_errors = 0;
   int checked = 0;
   logic [31:0] seed = 32'hba96;
   // register values drawn for one round of random traffic
   logic [7:0] rg, bg;
   logic [7:0] shadow [4] = '{8'h00, 8'h00, 8'h00, 8'h00};

   adc_reference_input_select i_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pin_analog_sel(pin_analog_sel),
      .amp_enable(amp_enable), .amp_gain_select(amp_gain_select),
      .amp_pin_switch(amp_pin_switch), .amp_bandgap_switch(amp_bandgap_switch),
      .bandgap_enable(bandgap_enable), .ref_switch(ref_switch),
      .ref_pin_switch(ref_pin_switch), .input_switch(input_switch),
      .channel_switch(channel_switch), .pin_function_off(pin_function_off),
      .pull_high_off(pull_high_off), .direction_override(direction_override));

   // free-running 50 MHz clock
   always #10 clk = ~clk;

   // next pseudo-random word
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // stored bits of each register
   function automatic logic [7:0] mask(input logic [1:0] a);
      return (a == 2'h0) ? 8'h9f : ((a == 2'h1) ? 8'h01 : 8'h0f);
   endfunction
   // expected one-hot reference switch from the reference field
   function automatic logic [2:0] exp_ref(input logic [7:0] rg);
      return rg[3] ? 3'h4 : (rg[2] ? 3'h2 : 3'h1);
   endfunction
   // expected converter input switch from the source field
   function automatic logic [7:0] exp_in(input logic [3:0] s);
      case (s)
         4'h1: return 8'h02;
         4'h2: return 8'h04;
         4'h3: return 8'h08;
         4'h5: return 8'h10;
         4'h6: return 8'h20;
         4'h7: return 8'h40;
         4'h8, 4'h9, 4'ha, 4'hb: return 8'h80;
         default: return 8'h01;
      endcase
   endfunction
   // expected channel switch: only external sources and valid channels close one
   function automatic logic [8:0] exp_chan(input logic [3:0] s, input logic [3:0] c);
      if (exp_in(s) != 8'h01 || c > 4'h8 || c == 4'h2) return 9'h000;
      return 9'h001 << c;
   endfunction

   // one comparison, counted and reported on mismatch
   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // single-cycle register write, shadow keeps the stored bits
   task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      shadow[a] = d & mask(a);
   endtask
   // read, data in the next cycle only, zero afterwards
   task automatic read_reg(input logic [1:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 compare(rdata, shadow[a]);
      @(posedge clk);
      #1 compare(rdata, 8'h00);
   endtask
   // all decoded outputs against the shadow registers
   task automatic check_all();
      @(negedge clk);
      compare(amp_enable, shadow[0][7]);
      compare(amp_pin_switch, !shadow[0][4]);
      compare(amp_bandgap_switch, shadow[0][4]);
      compare(ref_switch, exp_ref(shadow[0]));
      compare(ref_pin_switch, shadow[0][3:2] == 2'b01);
      compare(amp_gain_select, shadow[0][1:0]);
      compare(bandgap_enable, shadow[1][0]);
      compare(input_switch, exp_in(shadow[3][3:0]));
      compare(channel_switch, exp_chan(shadow[3][3:0], shadow[2][3:0]));
      compare(pin_function_off, pin_analog_sel);
      compare(pull_high_off, pin_analog_sel);
      compare(direction_override, pin_analog_sel);
      compare(rdata, 8'h00);
   endtask
   // verdict and end of run
   task automatic end_of_test();
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      check_all();
      for (int a = 0; a < 4; a++) read_reg(a[1:0]);
      write_reg(2'h1, 8'hff);
      repeat (adc_ref_pkg::BANDGAP_START_CYCLES) @(posedge clk);
      write_reg(2'h0, 8'hff);
      read_reg(2'h0);
      read_reg(2'h1);
      check_all();
      // every source code with a random channel
      for (int s = 0; s < 16; s++) begin
         seed = lfsr(seed);
         write_reg(2'h3, {seed[7:4], s[3:0]});
         write_reg(2'h2, seed[15:8]);
         check_all();
      end
      // every channel code, each under one external source code in rotation
      for (int c = 0; c < 16; c++) begin
         write_reg(2'h2, c[7:0]);
         write_reg(2'h3, (c % 3 == 0) ? 8'h00 : ((c % 3 == 1) ? 8'h04 : {6'h03, c[1:0]}));
         check_all();
      end
      // random traffic on all registers and pin settings
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         @(posedge clk);
         pin_analog_sel <= seed[24:16];
         rg = seed[7:0] ^ seed[31:24];
         bg = seed[15:8] ^ seed[31:24];
         rg[4] = rg[4] & bg[0];
         rg[7] = rg[7] | rg[3];
         if (rg[4]) begin
            write_reg(2'h1, bg);
            repeat (adc_ref_pkg::BANDGAP_START_CYCLES) @(posedge clk);
            write_reg(2'h0, rg);
         end else begin
            write_reg(2'h0, rg);
            write_reg(2'h1, bg);
         end
         write_reg(2'h2, seed[23:16]);
         write_reg(2'h3, seed[31:24]);
         check_all();
         read_reg(seed[1:0]);
      end
      // reset in mid-run clears every register
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      shadow = '{8'h00, 8'h00, 8'h00, 8'h00};
      check_all();
      end_of_test();
   end
endmodule // testbench
